// ---- src/sie_pkg.sv ----
// Overview of operation
// - diagnosis bits 1:0 show CAN transceiver state, offline while transceiver supply is off
// - transceiver supply flag sets again on reactivation
// - address 01 selects interrupt enable register
// - select bit picks status or enable feedback
// - read-only bit blocks loading of enable bits
// - watchdog overflow in standby with enable set: interrupt, else reset
// - overflow clears watchdog enable; host rewrites it
// - temperature warning change raises interrupt if enabled
// - ground shift change raises interrupt if enabled
// - wrong clock count: interrupt, reset in start-up/restart
// - disabled: wrong clock count ignored, no interrupt
// - battery sense falling edge raises interrupt if enabled
// - regulator flag clearing raises interrupt if enabled
// - CAN fault code change raises interrupt if enabled
// - LIN fault code change raises interrupt if enabled
// - wake falling edge interrupts in normal/flash/standby
// - wake disabled: reset in standby, else nothing
// - watchdog restart while off raises interrupt
// - CAN event: wake interrupt or standby reset
// - LIN event: wake interrupt or standby reset
// - wake input acts only with global enable
package sie_pkg;

  // ---------------------------------------------------------------
  // frame layout
  // ---------------------------------------------------------------
  localparam int FRAME_BITS = 16;
  localparam int HEAD_BITS = 4;
  localparam int ENABLE_BITS = 12;
  localparam logic [1:0] ADDR_DIAG = 2'h0;
  localparam logic [1:0] ADDR_IRQ_ENABLE = 2'h1;
  localparam int HEAD_ADDR_HI = 3;
  localparam int HEAD_ADDR_LO = 2;
  localparam int HEAD_RRS = 1;
  localparam int HEAD_NO_WRITE = 0;

  // ---------------------------------------------------------------
  // enable / pending bit positions
  // ---------------------------------------------------------------
  localparam int BIT_WDT = 11;
  localparam int BIT_OVERTEMP = 10;
  localparam int BIT_GROUND_SHIFT = 9;
  localparam int BIT_CLOCK_COUNT = 8;
  localparam int BIT_BATTERY = 7;
  localparam int BIT_VOLTAGE = 6;
  localparam int BIT_CAN_FAULT = 5;
  localparam int BIT_LIN_FAULT = 4;
  localparam int BIT_LOCAL_WAKE = 3;
  localparam int BIT_WDT_RESTART = 2;
  localparam int BIT_CAN_WAKE = 1;
  localparam int BIT_LIN_WAKE = 0;

  // ---------------------------------------------------------------
  // diagnosis word positions
  // ---------------------------------------------------------------
  localparam int DIAG_GROUND_SHIFT = 11;
  localparam int DIAG_CAN_FAULT_LO = 7;
  localparam int DIAG_LIN_FAULT_LO = 5;
  localparam int DIAG_AUX_OK = 4;
  localparam int DIAG_TRX_OK = 3;
  localparam int DIAG_MAIN_OK = 2;
  localparam logic [1:0] CAN_STATE_OFFLINE = 2'h0;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [11:0] IRQ_ENABLE_RESET = 12'h000;
  localparam logic [11:0] PENDING_RESET = 12'h000;
  localparam logic SUPPLY_FLAG_RESET = 1'b1;
  localparam logic PIN_IDLE_RESET = 1'b1;

  // ---------------------------------------------------------------
  // operating modes, one-hot
  // ---------------------------------------------------------------
  typedef enum logic [4:0] {
    MODE_STARTUP = 5'h01,
    MODE_RESTART = 5'h02,
    MODE_STANDBY = 5'h04,
    MODE_NORMAL = 5'h08,
    MODE_FLASH = 5'h10
  } sie_mode_e;

endpackage

// ---- src/sie_sync_edge.sv ----
`timescale 1ns/10ps
module sie_sync_edge (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // asynchronous pin
  input wire logic pin,
  // synchronised level and edges
  output logic level,
  output logic rise,
  output logic fall
);

  logic stage1;
  logic stage2;
  logic last;

  // ---------------------------------------------------------------
  // two-stage synchroniser and edge finder
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      // pins rest high, so starting high keeps a false edge out of reset
      stage1 <= sie_pkg::PIN_IDLE_RESET;
      stage2 <= sie_pkg::PIN_IDLE_RESET;
      last <= sie_pkg::PIN_IDLE_RESET;
    end else begin
      stage1 <= pin;
      stage2 <= stage1;
      last <= stage2;
    end
  end

  assign level = stage2;
  assign rise = stage2 & ~last;
  assign fall = ~stage2 & last;

endmodule

// ---- src/sie_spi_frame.sv ----
`timescale 1ns/10ps
module sie_spi_frame (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // serial pins
  input wire logic spi_sclk,
  input wire logic spi_sdi,
  input wire logic spi_cs_n,
  output logic spi_sdo,
  output logic spi_sdo_oe,
  // answer word, valid once the header is in
  input wire logic [11:0] tx_word,
  output logic [3:0] head,
  output logic resp_load,
  // end of frame
  output logic frame_done,
  output logic [15:0] frame_word,
  output logic count_ok
);

  logic sclk_rise;
  logic sclk_fall;
  logic cs_n_level;
  logic cs_fall;
  logic cs_rise;
  logic sdi_level;
  logic [15:0] rx_shift;
  logic [11:0] tx_shift;
  logic [4:0] bit_cnt;

  sie_sync_edge u_sclk (.clk(clk), .sys_rst(sys_rst), .pin(spi_sclk),
    .level(), .rise(sclk_rise), .fall(sclk_fall));
  sie_sync_edge u_cs (.clk(clk), .sys_rst(sys_rst), .pin(spi_cs_n),
    .level(cs_n_level), .rise(cs_rise), .fall(cs_fall));
  sie_sync_edge u_sdi (.clk(clk), .sys_rst(sys_rst), .pin(spi_sdi),
    .level(sdi_level), .rise(), .fall());

  wire active = ~cs_n_level;
  wire at_head = bit_cnt == 5'(sie_pkg::HEAD_BITS);
  wire cnt_full = &bit_cnt;

  assign head = rx_shift[3:0];

  // ---------------------------------------------------------------
  // receive side: sample on rising serial clock
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rx_shift <= 16'h0000;
      bit_cnt <= 5'h00;
    end else if (cs_fall) begin
      rx_shift <= 16'h0000;
      bit_cnt <= 5'h00;
    end else if (active && sclk_rise) begin
      rx_shift <= {rx_shift[14:0], sdi_level};
      bit_cnt <= cnt_full ? bit_cnt : bit_cnt + 5'h01;
    end
  end

  // ---------------------------------------------------------------
  // transmit side: change on falling serial clock
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      tx_shift <= 12'h000;
      spi_sdo <= 1'b0;
      spi_sdo_oe <= 1'b0;
      resp_load <= 1'b0;
    end else begin
      resp_load <= 1'b0;
      if (cs_fall) begin
        spi_sdo <= 1'b0;
        spi_sdo_oe <= 1'b1;
      end else if (cs_rise) begin
        spi_sdo_oe <= 1'b0;
      end else if (active && sclk_fall && at_head) begin
        spi_sdo <= tx_word[11];
        tx_shift <= {tx_word[10:0], 1'b0};
        resp_load <= 1'b1;
      end else if (active && sclk_fall && bit_cnt > 5'(sie_pkg::HEAD_BITS)) begin
        spi_sdo <= tx_shift[11];
        tx_shift <= {tx_shift[10:0], 1'b0};
      end
    end
  end

  // ---------------------------------------------------------------
  // frame end on chip-select release
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      frame_done <= 1'b0;
      frame_word <= 16'h0000;
      count_ok <= 1'b0;
    end else begin
      frame_done <= cs_rise;
      if (cs_rise) begin
        frame_word <= rx_shift;
        count_ok <= bit_cnt == 5'(sie_pkg::FRAME_BITS);
      end
    end
  end

endmodule

// ---- src/sie_irq_enable.sv ----
`timescale 1ns/10ps
module sie_irq_enable (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // serial port to the host
  input wire logic spi_sclk,
  input wire logic spi_sdi,
  input wire logic spi_cs_n,
  output logic spi_sdo,
  output logic spi_sdo_oe,
  // operating mode
  input wire logic [4:0] mode,
  // watchdog
  input wire logic watchdog_overflow,
  input wire logic watchdog_restart,
  input wire logic watchdog_off,
  // monitors, same clock
  input wire logic temp_warning,
  input wire logic ground_shift,
  input wire logic [3:0] can_fault_code,
  input wire logic [1:0] lin_fault_code,
  input wire logic main_supply_low,
  input wire logic transceiver_supply,
  input wire logic aux_supply_ok,
  input wire logic [1:0] can_transceiver_state,
  // bus wake events, same clock
  input wire logic can_bus_event,
  input wire logic lin_bus_event,
  input wire logic can_active,
  input wire logic lin_active,
  // pins from outside
  input wire logic battery_sense,
  input wire logic wake_pin,
  input wire logic wake_port_en,
  // to the host and reset logic
  output logic interrupt_out_n,
  output logic reset_request
);

  logic [11:0] irq_enable;
  logic [11:0] pending;
  logic [11:0] read_snapshot;
  logic snapshot_is_status;
  logic main_supply_ok_flag;
  logic transceiver_supply_ok_flag;
  logic aux_supply_ok_flag;
  logic temp_last;
  logic gs_last;
  logic trx_last;
  logic [3:0] can_fault_last;
  logic [1:0] lin_fault_last;
  logic [11:0] tx_word;
  logic [3:0] head;
  logic resp_load;
  logic frame_done;
  logic [15:0] frame_word;
  logic count_ok;
  logic bat_fall;
  logic wake_fall;

  // ---------------------------------------------------------------
  // serial frame engine and pin synchronisers
  // ---------------------------------------------------------------
  sie_spi_frame u_spi (
    .clk(clk),
    .sys_rst(sys_rst),
    .spi_sclk(spi_sclk),
    .spi_sdi(spi_sdi),
    .spi_cs_n(spi_cs_n),
    .spi_sdo(spi_sdo),
    .spi_sdo_oe(spi_sdo_oe),
    .tx_word(tx_word),
    .head(head),
    .resp_load(resp_load),
    .frame_done(frame_done),
    .frame_word(frame_word),
    .count_ok(count_ok)
  );

  sie_sync_edge u_bat (
    .clk(clk),
    .sys_rst(sys_rst),
    .pin(battery_sense),
    .level(),
    .rise(),
    .fall(bat_fall)
  );

  sie_sync_edge u_wake (
    .clk(clk),
    .sys_rst(sys_rst),
    .pin(wake_pin),
    .level(),
    .rise(),
    .fall(wake_fall)
  );

  // ---------------------------------------------------------------
  // mode decode
  // ---------------------------------------------------------------
  wire in_standby = mode == sie_pkg::MODE_STANDBY;
  wire in_run = (mode == sie_pkg::MODE_NORMAL) || (mode == sie_pkg::MODE_FLASH);
  wire in_boot = (mode == sie_pkg::MODE_STARTUP) || (mode == sie_pkg::MODE_RESTART);

  // ---------------------------------------------------------------
  // header and frame decode
  // ---------------------------------------------------------------
  wire [1:0] head_addr = head[sie_pkg::HEAD_ADDR_HI:sie_pkg::HEAD_ADDR_LO];
  wire head_rrs = head[sie_pkg::HEAD_RRS];
  wire head_irq_sel = head_addr == sie_pkg::ADDR_IRQ_ENABLE;
  wire head_diag_sel = head_addr == sie_pkg::ADDR_DIAG;

  wire [1:0] fr_addr = frame_word[15:14];
  wire fr_rrs = frame_word[13];
  wire fr_no_write = frame_word[12];
  wire frame_ok = frame_done & count_ok;
  wire frame_bad = frame_done & ~count_ok;
  wire enable_write = frame_ok && fr_addr == sie_pkg::ADDR_IRQ_ENABLE && !fr_no_write;
  wire status_read = frame_ok && fr_addr == sie_pkg::ADDR_IRQ_ENABLE && fr_rrs;
  wire diag_read = frame_ok && fr_addr == sie_pkg::ADDR_DIAG && fr_rrs;

  // ---------------------------------------------------------------
  // system diagnosis word
  // ---------------------------------------------------------------
  wire [1:0] can_state_shown = transceiver_supply ? can_transceiver_state
                                                  : sie_pkg::CAN_STATE_OFFLINE;
  wire [15:0] diag_word = {
    4'h0,
    ground_shift,
    can_fault_code,
    lin_fault_code,
    aux_supply_ok_flag,
    transceiver_supply_ok_flag,
    main_supply_ok_flag,
    can_state_shown
  };

  // ---------------------------------------------------------------
  // answer selection
  // ---------------------------------------------------------------
  wire [11:0] feedback_word = irq_enable;
  wire [11:0] irq_answer = head_rrs ? pending : feedback_word;
  wire [11:0] diag_answer = head_rrs ? diag_word[11:0] : 12'h000;
  assign tx_word = head_irq_sel ? irq_answer : (head_diag_sel ? diag_answer : 12'h000);

  // ---------------------------------------------------------------
  // wake decode: irq check for the bus sources only, reset check shared by the bus and local wake sources
  // ---------------------------------------------------------------
  function automatic logic bus_wake_irq(input logic ev, input logic busy,
                                        input logic stby, input logic run);
    return ev & (stby | (run & ~busy));
  endfunction

  function automatic logic wake_rst(input logic ev, input logic en, input logic stby);
    return ev & ~en & stby;
  endfunction

  // ---------------------------------------------------------------
  // event detection
  // ---------------------------------------------------------------
  wire trx_fell = trx_last & ~transceiver_supply;
  wire trx_rose = ~trx_last & transceiver_supply;
  wire main_clear = main_supply_low & main_supply_ok_flag;
  wire trx_clear = trx_fell & transceiver_supply_ok_flag;
  wire aux_clear = ~aux_supply_ok & aux_supply_ok_flag;
  wire wake_event = wake_fall & wake_port_en;
  wire wdt_irq_sel = irq_enable[sie_pkg::BIT_WDT] & in_standby;

  wire ev_wdt = watchdog_overflow & wdt_irq_sel;
  wire ev_temp = temp_warning ^ temp_last;
  wire ev_gs = ground_shift ^ gs_last;
  wire ev_count = frame_bad & ~in_boot;
  wire ev_bat = bat_fall;
  wire ev_volt = main_clear | trx_clear | aux_clear;
  wire ev_can_fault = can_fault_code != can_fault_last;
  wire ev_lin_fault = lin_fault_code != lin_fault_last;
  wire ev_wake = wake_event & (in_run | in_standby);
  wire ev_wdt_restart = watchdog_restart & watchdog_off;
  wire ev_can_wake = bus_wake_irq(can_bus_event, can_active, in_standby, in_run);
  wire ev_lin_wake = bus_wake_irq(lin_bus_event, lin_active, in_standby, in_run);

  wire [11:0] raw_events = {
    ev_wdt,
    ev_temp,
    ev_gs,
    ev_count,
    ev_bat,
    ev_volt,
    ev_can_fault,
    ev_lin_fault,
    ev_wake,
    ev_wdt_restart,
    ev_can_wake,
    ev_lin_wake
  };
  wire [11:0] new_events = raw_events & irq_enable;

  // ---------------------------------------------------------------
  // reset causes
  // ---------------------------------------------------------------
  wire rst_wdt = watchdog_overflow & ~wdt_irq_sel;
  wire rst_count = frame_bad & irq_enable[sie_pkg::BIT_CLOCK_COUNT] & in_boot;
  wire rst_wake = wake_rst(wake_event, irq_enable[sie_pkg::BIT_LOCAL_WAKE], in_standby);
  wire rst_can = wake_rst(can_bus_event, irq_enable[sie_pkg::BIT_CAN_WAKE], in_standby);
  wire rst_lin = wake_rst(lin_bus_event, irq_enable[sie_pkg::BIT_LIN_WAKE], in_standby);
  wire next_reset_request = rst_wdt | rst_count | rst_wake | rst_can | rst_lin;

  // ---------------------------------------------------------------
  // enable register
  // ---------------------------------------------------------------
  logic [11:0] next_irq_enable;
  always_comb begin
    next_irq_enable = irq_enable;
    if (watchdog_overflow) begin
      next_irq_enable[sie_pkg::BIT_WDT] = 1'b0;
    end
    if (enable_write) begin
      next_irq_enable = frame_word[11:0];
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      irq_enable <= sie_pkg::IRQ_ENABLE_RESET;
    end else begin
      irq_enable <= next_irq_enable;
    end
  end

  // ---------------------------------------------------------------
  // pending status, cleared by a read; new events win over the clear
  // ---------------------------------------------------------------
  wire [11:0] read_clear = status_read && snapshot_is_status ? read_snapshot : 12'h000;
  wire [11:0] next_pending = (pending & ~read_clear) | new_events;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pending <= sie_pkg::PENDING_RESET;
      read_snapshot <= sie_pkg::PENDING_RESET;
      snapshot_is_status <= 1'b0;
    end else begin
      pending <= next_pending;
      if (resp_load) begin
        read_snapshot <= pending;
        snapshot_is_status <= head_irq_sel & head_rrs;
      end
    end
  end

  // ---------------------------------------------------------------
  // regulator diagnosis flags
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      main_supply_ok_flag <= sie_pkg::SUPPLY_FLAG_RESET;
      transceiver_supply_ok_flag <= sie_pkg::SUPPLY_FLAG_RESET;
      aux_supply_ok_flag <= sie_pkg::SUPPLY_FLAG_RESET;
    end else begin
      if (main_supply_low) begin
        main_supply_ok_flag <= 1'b0;
      end else if (diag_read) begin
        main_supply_ok_flag <= 1'b1;
      end
      if (trx_fell) begin
        transceiver_supply_ok_flag <= 1'b0;
      end else if (trx_rose) begin
        transceiver_supply_ok_flag <= 1'b1;
      end
      aux_supply_ok_flag <= aux_supply_ok;
    end
  end

  // ---------------------------------------------------------------
  // history for change detection
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      temp_last <= 1'b0;
      gs_last <= 1'b0;
      trx_last <= 1'b0;
      can_fault_last <= 4'h0;
      lin_fault_last <= 2'h0;
    end else begin
      temp_last <= temp_warning;
      gs_last <= ground_shift;
      trx_last <= transceiver_supply;
      can_fault_last <= can_fault_code;
      lin_fault_last <= lin_fault_code;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      interrupt_out_n <= 1'b1;
      reset_request <= 1'b0;
    end else begin
      interrupt_out_n <= ~|next_pending;
      reset_request <= next_reset_request;
    end
  end

endmodule

// ---- test/sie_irq_enable_monitor.sv ----
`timescale 1ns/10ps
module sie_irq_enable_monitor (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // serial port
  input wire logic spi_cs_n,
  input wire logic spi_sdo_oe,
  // causes
  input wire logic [4:0] mode,
  input wire logic watchdog_overflow,
  input wire logic watchdog_restart,
  input wire logic temp_warning,
  input wire logic ground_shift,
  input wire logic [3:0] can_fault_code,
  input wire logic [1:0] lin_fault_code,
  input wire logic main_supply_low,
  input wire logic transceiver_supply,
  input wire logic aux_supply_ok,
  input wire logic can_bus_event,
  input wire logic lin_bus_event,
  input wire logic battery_sense,
  input wire logic wake_pin,
  // results
  input wire logic interrupt_out_n,
  input wire logic reset_request
);
  // ---------------------------------------------------------------
  // port relations
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  property p_oe_on;
    (!spi_cs_n)[*5] |-> spi_sdo_oe;
  endproperty
  a_oe_on: assert property (p_oe_on) else $error("sdo idle in frame");
  property p_oe_off;
    spi_cs_n[*5] |-> !spi_sdo_oe;
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("sdo driven idle");
  property p_wdt_reset;
    watchdog_overflow && mode != sie_pkg::MODE_STANDBY |=> reset_request;
  endproperty
  a_wdt_reset: assert property (p_wdt_reset) else $error("overflow no reset");
  property p_wdt_stby;
    watchdog_overflow && mode == sie_pkg::MODE_STANDBY |=> reset_request || !interrupt_out_n;
  endproperty
  a_wdt_stby: assert property (p_wdt_stby) else $error("overflow lost");
  property p_reset_mode;
    reset_request && !$past(watchdog_overflow) && !$past(can_bus_event)
      && !$past(lin_bus_event) |-> mode != sie_pkg::MODE_NORMAL && mode != sie_pkg::MODE_FLASH;
  endproperty
  a_reset_mode: assert property (p_reset_mode) else $error("reset in run mode");
  property p_can_norm;
    can_bus_event && !watchdog_overflow && mode == sie_pkg::MODE_NORMAL |=> !reset_request;
  endproperty
  a_can_norm: assert property (p_can_norm) else $error("can event reset");
  property p_lin_norm;
    lin_bus_event && !watchdog_overflow && mode == sie_pkg::MODE_NORMAL |=> !reset_request;
  endproperty
  a_lin_norm: assert property (p_lin_norm) else $error("lin event reset");
  property p_irq_hold;
    spi_cs_n[*8] ##0 !interrupt_out_n |=> !interrupt_out_n;
  endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("irq dropped");
  property p_quiet;
    (spi_cs_n && !(watchdog_overflow | watchdog_restart | can_bus_event | lin_bus_event)
      && $stable({temp_warning, ground_shift, can_fault_code, lin_fault_code, main_supply_low,
      transceiver_supply, aux_supply_ok, battery_sense, wake_pin}))[*8]
      |-> $stable(interrupt_out_n);
  endproperty
  a_quiet: assert property (p_quiet) else $error("irq moved idle");
endmodule

bind sie_irq_enable sie_irq_enable_monitor u_sie_irq_enable_monitor (.clk, .sys_rst,
  .spi_cs_n, .spi_sdo_oe, .mode, .watchdog_overflow, .watchdog_restart, .temp_warning,
  .ground_shift, .can_fault_code, .lin_fault_code, .main_supply_low, .transceiver_supply,
  .aux_supply_ok, .can_bus_event, .lin_bus_event, .battery_sense, .wake_pin,
  .interrupt_out_n, .reset_request);

// ---- test/sie_host_model.sv ----
`timescale 1ns/10ps
module sie_host_model (
  // clock
  input wire logic clk,
  // serial pins
  output logic spi_sclk,
  output logic spi_sdi,
  output logic spi_cs_n,
  input wire logic spi_sdo
);
  // ---------------------------------------------------------------
  // access of n clocks, msb first, sclk still between frames
  // ---------------------------------------------------------------
  initial begin
    spi_sclk = 1'b0;
    spi_sdi = 1'b0;
    spi_cs_n = 1'b1;
  end
  task automatic xfer(input logic [15:0] w, input int n, output logic [15:0] rep);
    rep = 16'h0000;
    @(posedge clk);
    spi_cs_n <= 1'b0;
    for (int i = 0; i < n; i++) begin
      spi_sclk <= 1'b0;
      spi_sdi <= w[15 - i];
      repeat (5) @(posedge clk);
      rep = {rep[14:0], spi_sdo};
      spi_sclk <= 1'b1;
      repeat (3) @(posedge clk);
    end
    spi_sclk <= 1'b0;
    repeat (4) @(posedge clk);
    spi_cs_n <= 1'b1;
    spi_sdi <= ~spi_sdi;
    repeat (8) @(posedge clk);
  endtask
endmodule

// ---- test/tb_top.sv ----
`timescale 1ns/10ps
module tb_top;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic spi_sclk, spi_sdi, spi_cs_n, spi_sdo, spi_sdo_oe, interrupt_out_n, reset_request;
  logic [4:0] mode = sie_pkg::MODE_NORMAL;
  logic watchdog_overflow = 1'b0, watchdog_restart = 1'b0, watchdog_off = 1'b1;
  logic temp_warning = 1'b0, ground_shift = 1'b0, main_supply_low = 1'b0;
  logic [3:0] can_fault_code = 4'h0;
  logic [1:0] lin_fault_code = 2'h0, can_transceiver_state = 2'h0;
  logic transceiver_supply = 1'b1, aux_supply_ok = 1'b1, battery_sense = 1'b1;
  logic can_bus_event = 1'b0, lin_bus_event = 1'b0, can_active = 1'b0, lin_active = 1'b0;
  logic wake_pin = 1'b1, wake_port_en = 1'b1;
  logic [15:0] r;
  int error_cnt = 0, n_checks = 0, cyc = 0, rr_cnt = 0;

  sie_irq_enable u_sie_irq_enable (.clk, .sys_rst, .spi_sclk, .spi_sdi, .spi_cs_n, .spi_sdo,
    .spi_sdo_oe, .mode, .watchdog_overflow, .watchdog_restart, .watchdog_off, .temp_warning,
    .ground_shift, .can_fault_code, .lin_fault_code, .main_supply_low, .transceiver_supply,
    .aux_supply_ok, .can_transceiver_state, .can_bus_event, .lin_bus_event, .can_active,
    .lin_active, .battery_sense, .wake_pin, .wake_port_en, .interrupt_out_n, .reset_request);
  sie_host_model u_sie_host_model (.clk, .spi_sclk, .spi_sdi, .spi_cs_n,
    .spi_sdo(spi_sdo_oe ? spi_sdo : ~spi_sdo));

  // ---------------------------------------------------------------
  // clock, reset pulse count, hang limit
  // ---------------------------------------------------------------
  always #25 clk = ~clk;
  always @(posedge clk) begin
    if (reset_request === 1'b1) rr_cnt++;
    cyc++;
    if (cyc == 40000) begin
      error_cnt++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    if (error_cnt == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic acc(input logic [15:0] w);
    u_sie_host_model.xfer(w, 16, r);
  endtask
  task automatic rd(input logic [15:0] w, input logic [15:0] exp);
    acc(w);
    chk(r, exp);
  endtask
  function automatic logic [15:0] dexp(input logic t);
    return {4'h0, ground_shift, can_fault_code, lin_fault_code, aux_supply_ok, t, 1'b1,
      t ? can_transceiver_state : 2'h0};
  endfunction
  // drives one cause of pending bit b in mode m, then restores the pulse and pin inputs; toggled monitor levels and mode stay
  task automatic fire(input int b, input logic [4:0] m);
    @(posedge clk);
    mode <= m;
    case (b)
      11: watchdog_overflow <= 1'b1;
      10: temp_warning <= ~temp_warning;
      9: ground_shift <= ~ground_shift;
      8: u_sie_host_model.xfer(16'h4000, 15, r);
      7: battery_sense <= 1'b0;
      6: aux_supply_ok <= 1'b0;
      5: can_fault_code <= can_fault_code + 4'h1;
      4: lin_fault_code <= lin_fault_code + 2'h1;
      3: wake_pin <= 1'b0;
      2: watchdog_restart <= 1'b1;
      1: can_bus_event <= 1'b1;
      default: lin_bus_event <= 1'b1;
    endcase
    @(posedge clk);
    {watchdog_overflow, watchdog_restart, can_bus_event, lin_bus_event} <= 4'h0;
    repeat (6) @(posedge clk);
    {battery_sense, aux_supply_ok, wake_pin} <= 3'h7;
    repeat (8) @(posedge clk);
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_regs();
    int rr0;
    rd(16'h5000, 16'h0000);
    acc(16'h4abc);
    rd(16'h5000, 16'h0abc);
    acc(16'h5555);
    rd(16'h5000, 16'h0abc);
    acc(16'h8fff);
    rd(16'h5000, 16'h0abc);
    u_sie_host_model.xfer(16'h4fff, 15, r);
    rd(16'h5000, 16'h0abc);
    acc(16'h4100);
    rr0 = rr_cnt;
    fire(8, sie_pkg::MODE_STARTUP);
    fire(8, sie_pkg::MODE_RESTART);
    chk(16'(rr_cnt - rr0), 16'h0002);
    rd(16'h7000, 16'h0000);
  endtask
  task automatic t_events_on();
    acc(16'h4fff);
    for (int b = 0; b < 12; b++) begin
      fire(b, (b == 11) ? sie_pkg::MODE_STANDBY
                        : (b[0] ? sie_pkg::MODE_FLASH : sie_pkg::MODE_NORMAL));
      chk({15'h0, interrupt_out_n}, 16'h0000);
      rd(16'h7000, 16'h0001 << b);
      chk({15'h0, interrupt_out_n}, 16'h0001);
    end
  endtask
  task automatic t_events_off();
    int rr0;
    int sb[4] = '{11, 3, 1, 0};
    rr0 = rr_cnt;
    acc(16'h4000);
    for (int b = 0; b < 11; b++) fire(b, sie_pkg::MODE_NORMAL);
    foreach (sb[i]) fire(sb[i], sie_pkg::MODE_STANDBY);
    rd(16'h7000, 16'h0000);
    chk(16'(rr_cnt - rr0), 16'h0004);
  endtask
  task automatic t_wdt();
    int rr0;
    acc(16'h4800);
    fire(11, sie_pkg::MODE_STANDBY);
    rd(16'h7000, 16'h0800);
    rd(16'h5000, 16'h0000);
    rr0 = rr_cnt;
    fire(11, sie_pkg::MODE_STANDBY);
    acc(16'h4800);
    fire(11, sie_pkg::MODE_NORMAL);
    rd(16'h7000, 16'h0000);
    chk(16'(rr_cnt - rr0), 16'h0002);
  endtask
  task automatic t_misc();
    acc(16'h400a);
    @(posedge clk);
    can_active <= 1'b1;
    wake_port_en <= 1'b0;
    fire(1, sie_pkg::MODE_NORMAL);
    fire(3, sie_pkg::MODE_NORMAL);
    rd(16'h7000, 16'h0000);
    can_active <= 1'b0;
    wake_port_en <= 1'b1;
  endtask
  task automatic t_diag();
    acc(16'h4000);
    for (int s = 0; s < 4; s++) begin
      can_transceiver_state <= 2'(s);
      @(posedge clk);
      rd(16'h3000, dexp(1'b1));
    end
    @(posedge clk);
    transceiver_supply <= 1'b0;
    rd(16'h3000, dexp(1'b0));
    transceiver_supply <= 1'b1;
    rd(16'h3000, dexp(1'b1));
  endtask

  initial begin
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (2) @(posedge clk);
    t_regs();
    t_events_on();
    t_events_off();
    t_wdt();
    t_misc();
    t_diag();
    wrap_up();
  end
endmodule
